// file: rtl/pwm_pkg.sv
// Shared constants and types for the enhanced PWM output unit
package pwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] DUTY_OFS = 6'h04;
  localparam logic [5:0] PERIOD_OFS = 6'h08;
  localparam logic [5:0] COUNT_OFS = 6'h0C;
  localparam logic [5:0] TIMER_OFS = 6'h10;
  localparam logic [5:0] DIR_OFS = 6'h14;
  localparam logic [5:0] DEADBAND_OFS = 6'h18;
  localparam logic [5:0] IRQ_STAT_OFS = 6'h1C;
  localparam logic [5:0] IRQ_MASK_OFS = 6'h20;
  localparam logic [5:0] PIN_STAT_OFS = 6'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [6:0] TIMER_RST = 7'h00;
  localparam logic [3:0] DIR_RST = 4'hF;
  localparam logic [6:0] DEADBAND_RST = 7'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CFG_LSB = 6;
  localparam int DLOW_LSB = 4;
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FULL_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_FULL_REV = 2'h3;

  // Timer control fields
  localparam int TMR_PRE_LSB = 0;
  localparam int TMR_ON_BIT = 2;
  localparam int TMR_POST_LSB = 3;

  // Prescaler terminal counts, four clocks per timer step times ratio
  localparam logic [7:0] PRE_TERM_1 = 8'h03;
  localparam logic [7:0] PRE_TERM_4 = 8'h0F;
  localparam logic [7:0] PRE_TERM_16 = 8'h3F;
  localparam logic [7:0] PRE_TERM_64 = 8'hFF;

  // Interrupt status bits
  localparam int IRQ_TIMEBASE = 0;
  localparam int IRQ_START = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [3:0] drive;
    logic [3:0] level;
  } pin_bus_t;

  typedef struct packed {
    logic [3:0] postscale;
    logic on;
    logic [1:0] prescale;
  } timer_cfg_t;

endpackage

// file: rtl/period_timebase.sv
// Period timebase: prescaler, 8-bit counter, period match, postscaler
`timescale 1ns/100ps
module period_timebase
(
  // Clock and reset
  input logic clock_i,
  input logic resetn_i,
  // Configuration
  input pwm_pkg::timer_cfg_t cfg_i,
  input logic [7:0] period_i,
  // Software counter write
  input logic load_i,
  input logic [7:0] load_value_i,
  // Timebase state
  output logic [7:0] count_o,
  output logic [1:0] fine_o,
  output logic match_o,
  output logic post_o
);
  import pwm_pkg::*;

  logic [7:0] pre_reg;
  logic [7:0] count_reg;
  logic [3:0] post_reg;
  logic [7:0] pre_term;
  logic tick;

  always_comb
  begin
    unique case (cfg_i.prescale)
      2'h0: pre_term = PRE_TERM_1;
      2'h1: pre_term = PRE_TERM_4;
      2'h2: pre_term = PRE_TERM_16;
      2'h3: pre_term = PRE_TERM_64;
    endcase
  end

  // Fine phase bits give the two extra duty bits
  always_comb
  begin
    unique case (cfg_i.prescale)
      2'h0: fine_o = pre_reg[1:0];
      2'h1: fine_o = pre_reg[3:2];
      2'h2: fine_o = pre_reg[5:4];
      2'h3: fine_o = pre_reg[7:6];
    endcase
  end

  assign tick = cfg_i.on && (pre_reg == pre_term);
  assign match_o = tick && (count_reg == period_i); // (R14)
  assign post_o = match_o && (post_reg == cfg_i.postscale); // (R13)
  assign count_o = count_reg;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pre_reg <= 8'h00;
    else if (!cfg_i.on || load_i || tick)
      pre_reg <= 8'h00;
    else
      pre_reg <= pre_reg + 8'h01; // (R12)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_reg <= 8'h00;
    else if (load_i)
      count_reg <= load_value_i; // (R11)
    else if (match_o)
      count_reg <= 8'h00; // (R16)
    else if (tick)
      count_reg <= count_reg + 8'h01;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      post_reg <= 4'h0;
    else if (post_o)
      post_reg <= 4'h0;
    else if (match_o)
      post_reg <= post_reg + 4'h1; // (R13)
  end

endmodule // period_timebase

// file: rtl/enhanced_pwm_output_control.sv
// Enhanced PWM unit with Wishbone registers and four steered outputs
//
// Summary of operation
// (R1) A PWM waveform with up to 10-bit duty resolution drives up to four pins.
// (R2) Period, duty and resolution come from period, timer, duty and control registers.
// (R3) In PWM mode the config field picks single, full forward, half or full reverse.
// (R4) Full forward holds A active, modulates D, holds B and C inactive.
// (R5) Full reverse holds C active, modulates B, holds A and D inactive.
// (R6) Mode bit 1 makes A and C active-low, mode bit 0 makes B and D active-low.
// (R7) After enabling, output waits for the next period start so no short pulse appears.
// (R8) A control register of all zeros releases the pins to ordinary port control.
// (R9) A pin is driven only while its direction bit selects output.
// (R10) Pins unused by the selected mode are never driven by this unit.
// (R11) The 8-bit period counter and period register are both readable and writable.
// (R12) The counter input passes a prescaler of 1:1, 1:4, 1:16 or 1:64.
// (R13) Period matches pass a postscaler of 1:1 to 1:16 before the timebase flag.
// (R14) A timebase event occurs when the counter equals the period register.
// (R15) Duty is the duty high byte above the two duty low bits.
// (R16) A match clears the counter and starts a period active; it ends at the duty count.
// (R17) Half-bridge drives A and B complementary with a programmable dead band.
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/100ps
module enhanced_pwm_output_control
(
  // Clock and reset
  input logic clock_i,
  input logic resetn_i,
  // Wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [5:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Output pins
  output pwm_pkg::pin_bus_t pins_o,
  // Interrupt
  output logic irq_o
);
  import pwm_pkg::*;

  typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_RUN} chan_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl_reg;
  logic [7:0] duty_high_reg;
  logic [7:0] period_reg;
  timer_cfg_t timer_reg;
  logic [3:0] dir_reg;
  logic [6:0] deadband_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Timebase
  logic [7:0] count;
  logic [1:0] fine;
  logic match;
  logic post;

  // Waveform
  chan_state_t state_reg;
  chan_state_t state_next;
  logic [9:0] duty_act_reg;
  logic raw_reg;
  logic raw_next;
  logic [6:0] dead_reg;
  pin_bus_t pins_reg;
  logic [3:0] act;
  logic [3:0] used;
  logic [3:0] pol;
  logic [3:0] drive;

  // Decoded fields
  logic [1:0] out_cfg;
  logic [3:0] mode;
  logic pwm_mode;
  logic owned;
  logic [9:0] duty_value;
  logic [9:0] phase;
  logic dead_gate;

  // Bus strobes
  logic req;
  logic wr;
  logic [1:0] irq_set;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign out_cfg = ctrl_reg[CFG_LSB +: 2];
  assign mode = ctrl_reg[MODE_LSB +: 4];
  assign pwm_mode = (mode[3:2] == MODE_PWM_TOP);
  assign owned = (ctrl_reg != CTRL_RST); // (R8)
  assign duty_value = {duty_high_reg, ctrl_reg[DLOW_LSB +: 2]}; // (R15)
  assign phase = {count, fine}; // (R1)

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, write lands on the acknowledged edge
  assign req = wb_cyc_i && wb_stb_i;
  assign wr = req && wb_we_i && ack_reg && wb_sel_i[0];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req && !ack_reg;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= 32'h0000_0000;
    else if (req && !ack_reg)
    begin
      unique case (wb_adr_i)
        CTRL_OFS: rdata_reg <= {24'h00_0000, ctrl_reg};
        DUTY_OFS: rdata_reg <= {24'h00_0000, duty_high_reg};
        PERIOD_OFS: rdata_reg <= {24'h00_0000, period_reg}; // (R11)
        COUNT_OFS: rdata_reg <= {24'h00_0000, count}; // (R11)
        TIMER_OFS: rdata_reg <= {25'h000_0000, timer_reg};
        DIR_OFS: rdata_reg <= {28'h000_0000, dir_reg};
        DEADBAND_OFS: rdata_reg <= {25'h000_0000, deadband_reg};
        IRQ_STAT_OFS: rdata_reg <= {30'h0000_0000, irq_stat_reg};
        IRQ_MASK_OFS: rdata_reg <= {30'h0000_0000, irq_mask_reg};
        PIN_STAT_OFS: rdata_reg <= {24'h00_0000, pins_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl_reg <= CTRL_RST;
    else if (wr && wb_adr_i == CTRL_OFS)
      ctrl_reg <= wb_dat_i[7:0]; // (R2)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      duty_high_reg <= DUTY_RST;
    else if (wr && wb_adr_i == DUTY_OFS)
      duty_high_reg <= wb_dat_i[7:0]; // (R2)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      period_reg <= PERIOD_RST;
    else if (wr && wb_adr_i == PERIOD_OFS)
      period_reg <= wb_dat_i[7:0]; // (R11)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      timer_reg <= timer_cfg_t'(TIMER_RST);
    else if (wr && wb_adr_i == TIMER_OFS)
      timer_reg <= timer_cfg_t'(wb_dat_i[6:0]); // (R2)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dir_reg <= DIR_RST;
    else if (wr && wb_adr_i == DIR_OFS)
      dir_reg <= wb_dat_i[3:0];
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      deadband_reg <= DEADBAND_RST;
    else if (wr && wb_adr_i == DEADBAND_OFS)
      deadband_reg <= wb_dat_i[6:0];
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_mask_reg <= IRQ_RST;
    else if (wr && wb_adr_i == IRQ_MASK_OFS)
      irq_mask_reg <= wb_dat_i[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, write one to clear, a new event wins over the clear
  always_comb
  begin
    irq_set = 2'h0;
    irq_set[IRQ_TIMEBASE] = post; // (R13)
    irq_set[IRQ_START] = (state_reg == CH_WAIT) && match;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_stat_reg <= IRQ_RST;
    else if (wr && wb_adr_i == IRQ_STAT_OFS)
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[1:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Period timebase
  period_timebase u_timebase
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .cfg_i(timer_reg),
    .period_i(period_reg),
    .load_i(wr && wb_adr_i == COUNT_OFS),
    .load_value_i(wb_dat_i[7:0]),
    .count_o(count),
    .fine_o(fine),
    .match_o(match),
    .post_o(post)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequencing: hold output off until a period boundary
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CH_IDLE:
      begin
        if (pwm_mode)
          state_next = CH_WAIT;
      end
      CH_WAIT:
      begin
        if (!pwm_mode)
          state_next = CH_IDLE;
        else if (match)
          state_next = CH_RUN; // (R7)
      end
      CH_RUN:
      begin
        if (!pwm_mode)
          state_next = CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_reg <= CH_IDLE;
    else
      state_reg <= state_next;
  end

  // Duty is taken at each period start so a period is never split
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      duty_act_reg <= 10'h000;
    else if (match)
      duty_act_reg <= duty_value; // (R15)
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulated waveform
  // Active from period start until the phase reaches the duty
  always_comb
  begin
    raw_next = 1'b0; // (R7)
    if (state_reg == CH_RUN)
      raw_next = (phase < duty_act_reg); // (R16)
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      raw_reg <= 1'b0;
    else
      raw_reg <= raw_next;
  end

  // Dead band restarts on every edge of the modulated signal
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      dead_reg <= 7'h00;
    else if (raw_next != raw_reg)
      dead_reg <= deadband_reg; // (R17)
    else if (dead_reg != 7'h00)
      dead_reg <= dead_reg - 7'h01;
  end

  assign dead_gate = (dead_reg == 7'h00) && (state_reg == CH_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Output steering, index 0 to 3 is pin A to D
  always_comb
  begin
    act = 4'h0;
    used = 4'h0;
    unique case (out_cfg)
      CFG_SINGLE:
      begin
        used = 4'b0001; // (R3)
        act[0] = raw_reg;
      end
      CFG_FULL_FWD:
      begin
        used = 4'b1111; // (R3)
        act[0] = (state_reg == CH_RUN); // (R4)
        act[3] = raw_reg; // (R4)
      end
      CFG_HALF:
      begin
        used = 4'b0011; // (R3)
        act[0] = raw_reg && dead_gate; // (R17)
        act[1] = !raw_reg && dead_gate; // (R17)
      end
      CFG_FULL_REV:
      begin
        used = 4'b1111; // (R3)
        act[2] = (state_reg == CH_RUN); // (R5)
        act[1] = raw_reg; // (R5)
      end
    endcase
  end

  // Polarity: A and C follow mode bit 1, B and D follow mode bit 0
  assign pol = {mode[0], mode[1], mode[0], mode[1]}; // (R6)

  // Drive only owned, used pins set as outputs
  assign drive = used & ~dir_reg & {4{pwm_mode && owned}}; // (R8) (R9) (R10)

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pins_reg <= '0;
    else
    begin
      pins_reg.drive <= drive; // (R10)
      pins_reg.level <= (act ^ pol) & drive; // (R6)
    end
  end

  assign pins_o = pins_reg;

endmodule // enhanced_pwm_output_control

// file: sim/pwm_unit_asserts.sv
// Port checks for the PWM unit
`timescale 1ns/100ps
module pwm_unit_asserts
(
  // Clock and reset
  input logic clock_i,
  input logic resetn_i,
  // Wishbone slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [5:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  // Pins and interrupt
  input pwm_pkg::pin_bus_t pins_o,
  input logic irq_o
);
  import pwm_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic wr_ack;
  logic rd_ack;
  assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_ack = wb_ack_o && !wb_we_i;

  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UPPER_ZERO: assert property (
    rd_ack |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (
    rd_ack && wb_adr_i > PIN_STAT_OFS |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  AST_PIN_READ: assert property (
    rd_ack && wb_adr_i == PIN_STAT_OFS |-> wb_dat_o[7:0] == $past(pins_o))
    else $error("pin state read mismatch");
  AST_UNDRIVEN: assert property (
    (pins_o.level & ~pins_o.drive) == 4'h0)
    else $error("level on undriven pin");
  AST_RELEASE: assert property (
    wr_ack && wb_adr_i == CTRL_OFS && wb_dat_i[7:0] == 8'h00
    |-> ##[1:3] pins_o.drive == 4'h0)
    else $error("pins kept after control clear");
  AST_DIR_IN: assert property (
    wr_ack && wb_adr_i == DIR_OFS && wb_dat_i[3:0] == 4'hF
    |-> ##[1:3] pins_o.drive == 4'h0)
    else $error("pins driven while set as inputs");
  AST_MASK_OFF: assert property (
    wr_ack && wb_adr_i == IRQ_MASK_OFS && wb_dat_i[1:0] == 2'h0
    |-> ##2 !irq_o [*3])
    else $error("interrupt high while masked");

  cover property (wr_ack);
  cover property (pins_o.drive == 4'hF);
  cover property (irq_o);
endmodule // pwm_unit_asserts

bind enhanced_pwm_output_control pwm_unit_asserts u_pwm_unit_asserts (
  .clock_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pins_o, .irq_o);

// file: sim/bridge_stage.sv
// Bridge stage model: pin A timing and shoot-through watch
`timescale 1ns/100ps
module bridge_stage
(
  // Clock and reset
  input logic clock_i,
  input logic resetn_i,
  // Pins from the unit
  input pwm_pkg::pin_bus_t pins_i,
  // Observations
  output logic [10:0] hi_len_o,
  output logic [10:0] lo_len_o,
  output logic overlap_o
);
  import pwm_pkg::*;
  logic [10:0] run_reg;
  logic last_reg;
  // Length of each pin A run
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_reg <= 11'h001;
      last_reg <= 1'b0;
      hi_len_o <= 11'h000;
      lo_len_o <= 11'h000;
    end
    else if (pins_i.level[0] == last_reg)
      run_reg <= run_reg + 11'h001;
    else
    begin
      run_reg <= 11'h001;
      last_reg <= pins_i.level[0];
      if (last_reg)
        hi_len_o <= run_reg;
      else
        lo_len_o <= run_reg;
    end
  end
  // Both half-bridge switches on
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      overlap_o <= 1'b0;
    else if (pins_i.drive == 4'h3 && pins_i.level[1:0] == 2'h3)
      overlap_o <= 1'b1;
  end
endmodule // bridge_stage

// file: sim/tb_top.sv
// Testbench for the enhanced PWM unit
`timescale 1ns/100ps
module tb_top;
  import pwm_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic overlap;
  logic [7:0] rd;
  logic [10:0] hi_len;
  logic [10:0] lo_len;
  pin_bus_t pins;
  int err_count = 0;
  int n_compared = 0;

  initial forever #50 clock_i = ~clock_i;

  enhanced_pwm_output_control u_enhanced_pwm_output_control (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_o(pins),
    .irq_o(irq));
  bridge_stage u_bridge_stage (.clock_i(clock_i), .resetn_i(resetn_i),
    .pins_i(pins), .hi_len_o(hi_len), .lo_len_o(lo_len),
    .overlap_o(overlap));

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tmo();
    err_count++;
    print_verdict();
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(logic w, logic [5:0] a, logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) tmo();
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wait_lvl(logic v);
    int n;
    n = 0;
    while (pins.level[0] !== v && n < 2000)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 2000) tmo();
    @(posedge clock_i);
  endtask

  task automatic s_reset();
    chk("pins", 8'h00, pins);
    wb(1'b0, CTRL_OFS, 8'h00);
    chk("ctrl", CTRL_RST, rd);
    wb(1'b0, DIR_OFS, 8'h00);
    chk("dir", DIR_RST, rd);
    wb(1'b0, 6'h3C, 8'h00);
    chk("unmapped", 8'h00, rd);
    wb(1'b1, PERIOD_OFS, 8'h03);
    wb(1'b0, PERIOD_OFS, 8'h00);
    chk("period", 8'h03, rd);
  endtask

  task automatic s_single();
    wb(1'b1, DUTY_OFS, 8'h02);
    wb(1'b1, TIMER_OFS, 8'h04);
    wb(1'b1, DIR_OFS, 8'h00);
    wb(1'b1, CTRL_OFS, 8'h1C);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    chk("first high", 11'h009, hi_len);
    chk("drive", 4'h1, pins.drive);
    wb(1'b0, PIN_STAT_OFS, 8'h00);
    chk("pin state drive", 4'h1, rd[7:4]);
    wb(1'b0, IRQ_STAT_OFS, 8'h00);
    chk("start flag", 1'b1, rd[IRQ_START]);
    for (int p = 0; p < 4; p++)
    begin
      wb(1'b1, TIMER_OFS, 8'h04 | 8'(p));
      repeat (3)
      begin
        wait_lvl(1'b1);
        wait_lvl(1'b0);
      end
      chk("high", 11'h009 << (2 * p), hi_len);
      chk("low", 11'h007 << (2 * p), lo_len);
    end
    wb(1'b1, TIMER_OFS, 8'h04);
  endtask

  task automatic s_modes();
    logic [3:0] e;
    logic [3:0] m;
    logic f;
    for (int i = 0; i < 8; i++)
    begin
      f = (i < 4);
      m = f ? 4'h7 : 4'hD;
      e = {i[0], f ~^ i[1], i[0], f ^ i[1]};
      wb(1'b1, CTRL_OFS, {f ? 2'h1 : 2'h3, 4'h7, 2'(i)});
      repeat (40) @(posedge clock_i);
      chk("full drive", 4'hF, pins.drive);
      chk("held", e & m, pins.level & m);
    end
    wb(1'b1, DIR_OFS, 8'h0A);
    repeat (3) @(posedge clock_i);
    chk("dir drive", 4'h5, pins.drive);
    wb(1'b1, CTRL_OFS, 8'h00);
    repeat (3) @(posedge clock_i);
    chk("released", 8'h00, pins);
    wb(1'b1, DIR_OFS, 8'h0F);
  endtask

  task automatic s_half();
    int g;
    g = 0;
    wb(1'b1, DEADBAND_OFS, 8'h02);
    wb(1'b1, DIR_OFS, 8'h00);
    wb(1'b1, CTRL_OFS, 8'h9C);
    repeat (100) @(posedge clock_i);
    chk("half drive", 4'h3, pins.drive);
    chk("overlap", 1'b0, overlap);
    repeat (32)
    begin
      @(posedge clock_i);
      if (pins.level[1:0] == 2'h0)
        g++;
    end
    chk("dead band", 8'h08, g);
  endtask

  task automatic s_irq();
    wb(1'b1, IRQ_MASK_OFS, 8'h00);
    wb(1'b1, TIMER_OFS, 8'h0C);
    repeat (80) @(posedge clock_i);
    chk("masked", 1'b0, irq);
    wb(1'b1, TIMER_OFS, 8'h00);
    wb(1'b0, IRQ_STAT_OFS, 8'h00);
    chk("match flag", 1'b1, rd[IRQ_TIMEBASE]);
    wb(1'b1, IRQ_MASK_OFS, 8'h01);
    repeat (2) @(posedge clock_i);
    chk("irq", 1'b1, irq);
    wb(1'b1, IRQ_STAT_OFS, 8'h03);
    repeat (2) @(posedge clock_i);
    chk("cleared", 1'b0, irq);
    wb(1'b1, COUNT_OFS, 8'h05);
    wb(1'b0, COUNT_OFS, 8'h00);
    chk("counter", 8'h05, rd);
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    s_reset();
    s_single();
    s_modes();
    s_half();
    s_irq();
    print_verdict();
  end
endmodule // tb_top
